// file: verilog/swr_policy.sv
// switch control register and per-packet routing policy, with apb access
`timescale 1ns/100ps
`include "swr_params.svh"
module swr_policy
   import swr_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int BUF_DEPTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // hot reset sequencer and datapath levels
   output logic hot_reset_eeprom_skip,
   output logic cut_through_en,
   // packet summaries from the ingress side
   input wire swr_pkt_t in_pkt,
   input wire logic in_valid,
   output logic in_ready,
   // decisions to the egress side
   output swr_dec_t out_dec,
   output logic out_valid,
   input wire logic out_ready,
   // credit return of silently discarded packets
   output logic credit_return,
   // one pulse per packet turned into an unsupported request
   output logic ur_event
);
   localparam int DEC_W = $bits(swr_dec_t);
   localparam int OCC_W = $clog2(BUF_DEPTH+1);

   swr_state_t s_q, s_d;

   // control fields, named for use below
   logic relaxed_order_off;
   logic peer_traffic_off;
   logic [1:0] downstream_devnum_check_mode;
   logic upstream_devnum_check_on;
   logic cut_through_off;
   logic lock_ignore;
   logic vendor_broadcast_drop;

   assign relaxed_order_off = s_q.ctrl[`SWR_RELAXED_OFF_BIT];
   assign peer_traffic_off = s_q.ctrl[`SWR_PEER_OFF_BIT];
   assign downstream_devnum_check_mode =
      s_q.ctrl[`SWR_DEVNUM_MODE_HI:`SWR_DEVNUM_MODE_LO];
   assign upstream_devnum_check_on = s_q.ctrl[`SWR_UP_CHECK_BIT];
   assign cut_through_off = s_q.ctrl[`SWR_CUT_OFF_BIT];
   assign lock_ignore = s_q.ctrl[`SWR_LOCK_IGNORE_BIT];
   assign vendor_broadcast_drop = s_q.ctrl[`SWR_BCAST_DROP_BIT];

   // level seen by the hot reset sequencer when it reaches the eeprom step
   assign hot_reset_eeprom_skip = s_q.ctrl[`SWR_EEPROM_SKIP_BIT];

   // store-and-forward forces whole-packet receipt on every port pair
   assign cut_through_en = !cut_through_off;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   logic apb_setup, apb_access, apb_wr;
   logic hit_ctrl, hit_stat, hit_any;
   logic [31:0] wr_bytes;
   logic [OCC_W-1:0] occ;

   assign apb_setup = psel && !penable;
   assign apb_access = psel && penable;
   assign hit_ctrl = (paddr == ADDR_W'(`SWR_CTRL_OFS));
   assign hit_stat = (paddr == ADDR_W'(`SWR_STAT_OFS));
   assign hit_any = hit_ctrl || hit_stat;
   assign apb_wr = apb_access && pwrite && hit_ctrl;

   // zero wait states: every access finishes in its first access cycle
   assign pready = 1'b1;
   // unmapped addresses and writes to the status word report an error
   assign pslverr = apb_access && (!hit_any || (pwrite && hit_stat));
   assign prdata = s_q.rdata;

   // byte strobes widened to a bit mask
   always_comb begin
      wr_bytes = '0;
      for (int i = 0; i < 4; i++) begin
         wr_bytes[i*8 +: 8] = {8{pstrb[i]}};
      end
   end

   // status word assembled from live counters and buffer fill
   logic [31:0] stat_word;
   always_comb begin
      stat_word = '0;
      stat_word[`SWR_STAT_FWD_LO +: 8] = s_q.fwd_cnt;
      stat_word[`SWR_STAT_UR_LO +: 8] = s_q.ur_cnt;
      stat_word[`SWR_STAT_DROP_LO +: 8] = s_q.drop_cnt;
      stat_word[`SWR_STAT_OCC_LO +: OCC_W] = occ;
   end

   // ------------------------------------------------------------------
   // per-packet classification
   // ------------------------------------------------------------------
   swr_chk_t chk_mode;
   logic dev_nonzero;
   logic down_dev_block;
   logic up_dev_hit;
   logic peer_block;
   logic bcast_drop;
   swr_act_t act;
   swr_dec_t dec;

   assign dev_nonzero = (in_pkt.dev_num != 5'h00);

   // encoding three has no defined meaning: treat as the strictest mode
   always_comb begin
      unique case (swr_chk_t'(downstream_devnum_check_mode))
         SWR_CHK_ALL: chk_mode = SWR_CHK_ALL;
         SWR_CHK_CFG: chk_mode = SWR_CHK_CFG;
         SWR_CHK_NONE: chk_mode = SWR_CHK_NONE;
         SWR_CHK_UNDEF: chk_mode = SWR_CHK_ALL;
      endcase
   end

   // device-number screen for the bus of a downstream link
   always_comb begin
      down_dev_block = 1'b0;
      if (in_pkt.id_routed && in_pkt.bus_is_down_link && dev_nonzero
          && !in_pkt.alt_routing_forward_enable) begin
         unique case (chk_mode)
            SWR_CHK_ALL: down_dev_block = 1'b1;
            SWR_CHK_CFG: down_dev_block = in_pkt.is_cfg_req;
            SWR_CHK_NONE: down_dev_block = 1'b0;
            default: down_dev_block = 1'b1;
         endcase
      end
   end

   // downstream arrival aimed at the upstream link's bus, nonzero device
   assign up_dev_hit = !in_pkt.from_upstream && in_pkt.id_routed
                       && in_pkt.bus_is_up_link && dev_nonzero;

   // peer traffic: from a downstream port, not toward the upstream port
   assign peer_block = peer_traffic_off && !in_pkt.from_upstream
                       && !in_pkt.to_upstream;

   // vendor type 1 broadcasts coming down from the root
   assign bcast_drop = vendor_broadcast_drop && in_pkt.from_upstream
                       && in_pkt.vdm_bcast_t1;

   // priority: discard, peer block, upstream check, downstream check
   always_comb begin
      act = SWR_ACT_FWD;
      if (bcast_drop) begin
         act = SWR_ACT_DROP;
      end else if (peer_block) begin
         act = SWR_ACT_UR;
      end else if (up_dev_hit && upstream_devnum_check_on) begin
         act = in_pkt.is_cpl ? SWR_ACT_DROP : SWR_ACT_UR;
      end else if (up_dev_hit) begin
         act = SWR_ACT_FWD;
      end else if (down_dev_block) begin
         // completions have no requester to answer, so they vanish
         act = in_pkt.is_cpl ? SWR_ACT_DROP : SWR_ACT_UR;
      end
   end

   // decision word carried through the buffer
   always_comb begin
      dec.tag = in_pkt.tag;
      dec.action = act;
      dec.relaxed_ok = in_pkt.relaxed_attr && !relaxed_order_off;
      dec.lock_effect = in_pkt.locked && !lock_ignore;
      dec.cut_through = !cut_through_off;
   end

   // ------------------------------------------------------------------
   // decision buffer
   // ------------------------------------------------------------------
   logic take, push_ok, buf_in_ready;
   logic [DEC_W-1:0] buf_out;

   // back-pressure reaches the ingress even for packets that get dropped,
   // which keeps the accept rule simple at the cost of a stall now and then
   assign in_ready = buf_in_ready;
   assign take = in_valid && buf_in_ready;
   // discarded packets never enter the buffer: contents are gone
   assign push_ok = in_valid && (act != SWR_ACT_DROP);

   swr_buf #(
      .WIDTH(DEC_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .clk(pclk),
      .rst_n(presetn),
      .in_data(dec),
      .in_valid(push_ok),
      .in_ready(buf_in_ready),
      .out_data(buf_out),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .occupancy(occ)
   );

   assign out_dec = swr_dec_t'(buf_out);

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.credit_ret = 1'b0;
      s_d.ur_evt = 1'b0;

      // only documented bits take writes; bits 0..5 and reserved stay zero
      if (apb_wr) begin
         s_d.ctrl = (s_q.ctrl & ~(wr_bytes & `SWR_CTRL_WMASK))
                    | (pwdata & wr_bytes & `SWR_CTRL_WMASK);
      end

      // read data latched in setup so it comes from a flop in access
      if (apb_setup && !pwrite) begin
         if (hit_ctrl) begin
            s_d.rdata = s_q.ctrl & `SWR_CTRL_WMASK;
         end else if (hit_stat) begin
            s_d.rdata = stat_word;
         end else begin
            s_d.rdata = '0;
         end
      end

      // counters wrap; they are a debug aid, not an error status
      if (take) begin
         unique case (act)
            SWR_ACT_FWD: s_d.fwd_cnt = s_q.fwd_cnt + 8'h01;
            SWR_ACT_UR: begin
               s_d.ur_cnt = s_q.ur_cnt + 8'h01;
               s_d.ur_evt = 1'b1;
            end
            SWR_ACT_DROP: begin
               s_d.drop_cnt = s_q.drop_cnt + 8'h01;
               s_d.credit_ret = 1'b1;
            end
            default: s_d.fwd_cnt = s_q.fwd_cnt;
         endcase
      end
   end

   assign credit_return = s_q.credit_ret;
   assign ur_event = s_q.ur_evt;

   // only power-up reset clears the word; hot reset never reaches here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.ctrl <= `SWR_CTRL_RESET;
         s_q.rdata <= 32'h0000_0000;
         s_q.fwd_cnt <= 8'h00;
         s_q.ur_cnt <= 8'h00;
         s_q.drop_cnt <= 8'h00;
         s_q.credit_ret <= 1'b0;
         s_q.ur_evt <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : swr_policy

// file: pkg/swr_params.svh
// offsets, field positions, reset values and masks of the routing policy block
// How it works
// - eeprom skip bit set: hot reset leaves out the serial eeprom load step.
// - ordering bit clear: packets flagged relaxed are passed on as relaxed.
// - ordering bit set: everything strongly ordered, relaxed flag in packets ignored.
// - peer bit set: downstream arrivals not aimed upstream become unsupported requests.
// - full checking: config to downstream bus only reaches device 0, else unsupported.
// - checking field has no effect on a port with alternate routing forward enabled.
// - field zero: block every id-routed packet to downstream bus, nonzero device.
// - field one: block only such config requests, deliver all other packets.
// - field two: deliver every packet whatever device number it names.
// - upstream check off: downstream packets to upstream bus, nonzero device, go up.
// - upstream check on: such requests unsupported, such completions silently dropped.
// - cut-through bit set: every packet received whole before forwarding.
// - cut-through bit clear: cut-through forwarding whenever possible.
// - lock-ignore bit set: locked packets lose lock effects, routed as ordinary.
// - broadcast bit set: vendor type 1 broadcasts from upstream silently discarded.
// - silent discard returns credits, drops contents, sets no error status.
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

// register byte offsets
`define SWR_CTRL_OFS 12'h000
`define SWR_STAT_OFS 12'h004

// control field positions
`define SWR_EEPROM_SKIP_BIT 6
`define SWR_RELAXED_OFF_BIT 7
`define SWR_PEER_OFF_BIT 8
`define SWR_DEVNUM_MODE_LO 9
`define SWR_DEVNUM_MODE_HI 10
`define SWR_UP_CHECK_BIT 11
`define SWR_CUT_OFF_BIT 14
`define SWR_LOCK_IGNORE_BIT 15
`define SWR_BCAST_DROP_BIT 19

// reset value and writable bits of the control word
`define SWR_CTRL_RESET 32'h0000_0000
`define SWR_CTRL_WMASK 32'h0008_CFC0

// status field positions
`define SWR_STAT_FWD_LO 0
`define SWR_STAT_UR_LO 8
`define SWR_STAT_DROP_LO 16
`define SWR_STAT_OCC_LO 24

`endif

// file: pkg/swr_pkg.sv
// types shared by the routing policy block
package swr_pkg;

   // packet header summary presented by the switch core
   typedef struct packed {
      logic [7:0] tag;
      logic from_upstream;
      logic to_upstream;
      logic id_routed;
      logic is_cfg_req;
      logic is_cpl;
      logic bus_is_down_link;
      logic bus_is_up_link;
      logic [4:0] dev_num;
      logic relaxed_attr;
      logic locked;
      logic vdm_bcast_t1;
      logic alt_routing_forward_enable;
   } swr_pkt_t;

   typedef enum logic [1:0] {
      SWR_ACT_FWD = 2'b00,
      SWR_ACT_UR = 2'b01,
      SWR_ACT_DROP = 2'b10
   } swr_act_t;

   // routing decision handed to the egress side
   typedef struct packed {
      logic [7:0] tag;
      swr_act_t action;
      logic relaxed_ok;
      logic lock_effect;
      logic cut_through;
   } swr_dec_t;

   typedef enum logic [1:0] {
      SWR_CHK_ALL = 2'b00,
      SWR_CHK_CFG = 2'b01,
      SWR_CHK_NONE = 2'b10,
      SWR_CHK_UNDEF = 2'b11
   } swr_chk_t;

   // state of the policy block apart from its decision buffer
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] rdata;
      logic [7:0] fwd_cnt;
      logic [7:0] ur_cnt;
      logic [7:0] drop_cnt;
      logic credit_ret;
      logic ur_evt;
   } swr_state_t;

endpackage : swr_pkg

// file: verilog/swr_buf.sv
// two-entry decision buffer with valid/ready on both sides
`timescale 1ns/100ps
module swr_buf #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [$clog2(DEPTH+1)-1:0] occupancy
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } swr_buf_st_t;

   swr_buf_st_t s_q, s_d;
   logic push, pop;

   // full and empty straight from the count, so ready is honest
   assign in_ready = (s_q.cnt != CW'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data = s_q.mem[s_q.rp];
   assign occupancy = s_q.cnt;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer wrap by compare keeps odd depths legal
   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp = (s_q.wp == PW'(DEPTH-1)) ? '0 : s_q.wp + PW'(1);
      end
      if (pop) begin
         s_d.rp = (s_q.rp == PW'(DEPTH-1)) ? '0 : s_q.rp + PW'(1);
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + CW'(1);
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : swr_buf

// file: dv/swr_chk.sv
// assertions on the ports of the routing policy block
`timescale 1ns/100ps
module swr_chk
   import swr_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic hot_reset_eeprom_skip,
   input wire logic cut_through_en,
   input wire swr_pkt_t in_pkt,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire swr_dec_t out_dec,
   input wire logic out_valid,
   input wire logic credit_return,
   input wire logic ur_event
);
   logic [31:0] sh_q;
   logic wr, tk, dn;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr = psel && penable && pwrite && paddr == '0;
   assign tk = in_valid && in_ready;
   // id-routed from upstream to a downstream bus, nonzero device, check not bypassed
   assign dn = tk && in_pkt.id_routed && in_pkt.bus_is_down_link && in_pkt.dev_num != 5'h00
      && !in_pkt.alt_routing_forward_enable && in_pkt.from_upstream && !in_pkt.vdm_bcast_t1;
   // shadow of the control word; only defined bits are ever looked at
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sh_q <= '0;
      else if (wr) for (int i = 0; i < 4; i++) if (pstrb[i]) sh_q[i*8+:8] <= pwdata[i*8+:8];
   end
   property p_skip; wr && pstrb[0] |=> hot_reset_eeprom_skip == $past(pwdata[6]); endproperty
   a_skip: assert property (p_skip) else $error("eeprom skip level wrong");
   property p_cut; wr && pstrb[1] |=> cut_through_en == !$past(pwdata[14]); endproperty
   a_cut: assert property (p_cut) else $error("cut-through level wrong");
   property p_bcast;
      tk && in_pkt.from_upstream && in_pkt.vdm_bcast_t1 && sh_q[19] |=> credit_return && !ur_event;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast not discarded");
   property p_peer; tk && !in_pkt.from_upstream && !in_pkt.to_upstream && sh_q[8] |=> ur_event;
   endproperty
   a_peer: assert property (p_peer) else $error("peer packet not refused");
   property p_ro; out_valid |-> !(out_dec.relaxed_ok && sh_q[7]); endproperty
   a_ro: assert property (p_ro) else $error("relaxed order while disabled");
   property p_lock; out_valid |-> !(out_dec.lock_effect && sh_q[15]); endproperty
   a_lock: assert property (p_lock) else $error("lock effect while ignored");
   property p_m2; dn && sh_q[10:9] == 2'h2 |=> !credit_return && !ur_event; endproperty
   a_m2: assert property (p_m2) else $error("packet blocked with checking off");
   property p_m0; dn && sh_q[10] == sh_q[9] |=> credit_return || ur_event; endproperty
   a_m0: assert property (p_m0) else $error("nonzero device not blocked");
endmodule : swr_chk

// file: dv/swr_sink.sv
// egress side model: takes decisions, stalls at random or on command
`timescale 1ns/100ps
module swr_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold,
   output logic out_ready
);
   logic [7:0] lf_q;
   // lfsr stalls about one cycle in four, so the buffer really backs up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_q <= 8'h5A;
         out_ready <= 1'b0;
      end else begin
         lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
         out_ready <= !hold && lf_q[1:0] != 2'h0;
      end
   end
endmodule : swr_sink

// file: dv/swr_policy_test.sv
// self-checking bench of the routing policy block
`timescale 1ns/100ps
`include "swr_params.svh"
`define SWR_CMP(g, e, m) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %0t %s", $time, m); end end
module swr_policy_test
   import swr_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic in_valid = 1'b0;
   logic hold = 1'b0;
   swr_pkt_t in_pkt = '0;
   logic [31:0] prdata, rd, ctrl, rng = 32'h0000_0061;
   logic pready, pslverr, err, skip, cten, in_ready, out_valid, out_ready, cr, ur;
   swr_dec_t out_dec, e;
   swr_dec_t exq[$];
   int failures = 0, n_compared = 0, n_cr = 0, n_ur = 0, e_cr = 0, e_ur = 0, e_fw = 0;
   always #4 pclk = ~pclk;
   swr_policy i_swr_policy (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hot_reset_eeprom_skip(skip), .cut_through_en(cten),
      .in_pkt(in_pkt), .in_valid(in_valid), .in_ready(in_ready), .out_dec(out_dec),
      .out_valid(out_valid), .out_ready(out_ready), .credit_return(cr), .ur_event(ur));
   swr_sink i_swr_sink (.pclk(pclk), .presetn(presetn), .hold(hold), .out_ready(out_ready));
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs
   // random summary, kept self-consistent (config requests are id-routed etc.)
   function automatic swr_pkt_t rnd_pkt();
      swr_pkt_t p;
      logic [31:0] r;
      r = xs();
      p = r[23:0];
      p.to_upstream &= !p.from_upstream;
      p.is_cfg_req &= p.id_routed;
      p.is_cpl &= !p.is_cfg_req;
      p.bus_is_up_link = p.to_upstream && p.id_routed;
      p.bus_is_down_link = !p.to_upstream && p.id_routed;
      p.vdm_bcast_t1 &= p.from_upstream && !p.id_routed;
      if (r[31]) p.dev_num = 5'h00;
      return p;
   endfunction : rnd_pkt
   function automatic swr_dec_t exp_dec(swr_pkt_t p, logic [31:0] c);
      swr_dec_t d;
      logic up, blk;
      up = !p.from_upstream && p.bus_is_up_link && p.dev_num != 5'h00;
      blk = p.bus_is_down_link && p.dev_num != 5'h00 && !p.alt_routing_forward_enable
         && c[10:9] != 2'h2 && (c[10:9] != 2'h1 || p.is_cfg_req);
      d.tag = p.tag;
      d.relaxed_ok = p.relaxed_attr && !c[7];
      d.lock_effect = p.locked && !c[15];
      d.cut_through = !c[14];
      if (p.from_upstream && p.vdm_bcast_t1 && c[19]) d.action = SWR_ACT_DROP;
      else if (!p.from_upstream && !p.to_upstream && c[8]) d.action = SWR_ACT_UR;
      else if ((up && c[11]) || blk) d.action = p.is_cpl ? SWR_ACT_DROP : SWR_ACT_UR;
      else d.action = SWR_ACT_FWD;
      return d;
   endfunction : exp_dec
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && a == `SWR_CTRL_OFS) ctrl = d & `SWR_CTRL_WMASK;
   endtask : apb
   // valid stays up between packets; fw gives plain forwarded ones
   task automatic burst(input int n, input logic fw);
      swr_pkt_t p;
      for (int i = 0; i < n; i++) begin
         p = rnd_pkt();
         if (fw) p = {p.tag, 1'b1, 15'h0000};
         in_pkt <= p;
         in_valid <= 1'b1;
         do @(posedge pclk); while (in_ready !== 1'b1);
      end
      in_valid <= 1'b0;
   endtask : burst
   task automatic drain();
      while (exq.size() != 0 || out_valid !== 1'b0) @(posedge pclk);
      repeat (2) @(posedge pclk);
   endtask : drain
   // scoreboard: decisions in order, pulses counted
   always @(posedge pclk) begin
      if (presetn) begin
         if (in_valid && in_ready) begin
            e = exp_dec(in_pkt, ctrl);
            if (e.action == SWR_ACT_DROP) e_cr++;
            else exq.push_back(e);
            if (e.action == SWR_ACT_UR) e_ur++;
            if (e.action == SWR_ACT_FWD) e_fw++;
         end
         if (out_valid === 1'b1 && out_ready) `SWR_CMP(out_dec, exq.pop_front(), "decision")
         n_cr += (cr === 1'b1);
         n_ur += (ur === 1'b1);
      end
   end
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      $display("MISMATCH %0t watchdog expired", $time);
      results();
   end
   initial begin
      ctrl = 32'h0000_0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `SWR_CTRL_OFS, 32'h0000_0000);
      `SWR_CMP(rd, `SWR_CTRL_RESET, "ctrl reset value")
      `SWR_CMP(cten, 1'b1, "cut-through at reset")
      apb(1'b1, `SWR_CTRL_OFS, 32'hFFFF_FFFF);
      apb(1'b0, `SWR_CTRL_OFS, 32'h0000_0000);
      `SWR_CMP(rd, `SWR_CTRL_WMASK, "reserved bits")
      `SWR_CMP({skip, cten}, 2'h2, "control levels")
      // byte lane 1 left out: cut-through bit and bits 8..15 keep their ones
      pstrb <= 4'hD;
      apb(1'b1, `SWR_CTRL_OFS, 32'h0000_0000);
      pstrb <= 4'hF;
      ctrl = `SWR_CTRL_WMASK & 32'h0000_FF00;
      apb(1'b0, `SWR_CTRL_OFS, 32'h0000_0000);
      `SWR_CMP(rd, `SWR_CTRL_WMASK & 32'h0000_FF00, "byte strobes")
      `SWR_CMP({skip, cten}, 2'h0, "levels after lane write")
      apb(1'b1, `SWR_STAT_OFS, 32'hFFFF_FFFF);
      `SWR_CMP(err, 1'b1, "status write refused")
      apb(1'b0, 12'h008, 32'h0000_0000);
      `SWR_CMP({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read")
      $display("test registers done");
      // every checking mode twice, other control bits random
      for (int m = 0; m < 8; m++) begin
         rd = xs();
         rd[10:9] = m[1:0];
         apb(1'b1, `SWR_CTRL_OFS, rd);
         burst(40, 1'b0);
         drain();
         $display("test policy %0d done", m);
      end
      // stalled receiver: buffer fills, third word waits and is not lost
      apb(1'b1, `SWR_CTRL_OFS, 32'h0000_0000);
      hold <= 1'b1;
      repeat (2) @(posedge pclk);
      fork
         burst(3, 1'b1);
      join_none
      repeat (6) @(posedge pclk);
      `SWR_CMP(in_ready, 1'b0, "full buffer refuses")
      apb(1'b0, `SWR_STAT_OFS, 32'h0000_0000);
      `SWR_CMP(rd[25:24], 2'h2, "occupancy full")
      hold <= 1'b0;
      wait fork;
      drain();
      apb(1'b0, `SWR_STAT_OFS, 32'h0000_0000);
      `SWR_CMP(rd[23:0], {e_cr[7:0], e_ur[7:0], e_fw[7:0]}, "status counters")
      `SWR_CMP({n_cr, n_ur}, {e_cr, e_ur}, "pulse counts")
      $display("test buffer done");
      // power-up reset in mid-run clears the control word
      apb(1'b1, `SWR_CTRL_OFS, 32'hFFFF_FFFF);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      ctrl = 32'h0000_0000;
      apb(1'b0, `SWR_CTRL_OFS, 32'h0000_0000);
      `SWR_CMP(rd, 32'h0000_0000, "ctrl after reset")
      `SWR_CMP({skip, cten}, 2'h1, "levels after reset")
      $display("test reset done");
      results();
   end
endmodule : swr_policy_test
bind swr_policy swr_chk #(.ADDR_W(ADDR_W)) i_swr_chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .pstrb(pstrb), .hot_reset_eeprom_skip(hot_reset_eeprom_skip),
   .cut_through_en(cut_through_en), .in_pkt(in_pkt), .in_valid(in_valid),
   .in_ready(in_ready), .out_dec(out_dec), .out_valid(out_valid),
   .credit_return(credit_return), .ur_event(ur_event));
